/* core/standby_pkg.sv */
package standby_pkg;

   // ----------------------------------------------------------------
   // register reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] SETTLE_SEL_RESET = 8'h04;
   localparam logic [7:0] PSC_RESET        = 8'h00;
   localparam logic [7:0] POWER_SAVE_MODE_REG_RESET       = 8'h00;
   localparam int         STP_BIT          = 1;
   localparam int         PSM_BIT          = 0;
   localparam int         SEL_MSB          = 2;

   // ----------------------------------------------------------------
   // settle timing: exponents of oscillator periods
   // ----------------------------------------------------------------
   localparam int         SHORT_EXP        = 14;
   localparam int         LONG_EXP_BASE    = 15;
   localparam int         CNT_W            = 23;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SEL_SETTLE = 2'h0,
      SEL_PSC    = 2'h1,
      SEL_POWER_SAVE_MODE_REG   = 2'h2
   } reg_sel_e;

   typedef enum logic [4:0] {
      ST_NORMAL = 5'h01,
      ST_HALT   = 5'h02,
      ST_IDLE   = 5'h04,
      ST_STOP   = 5'h08,
      ST_SETTLE = 5'h10
   } mode_e;

   typedef struct packed {
      logic       valid;
      reg_sel_e   sel;
      logic [7:0] data;
      logic       special_seq;
   } reg_write_s;

   typedef struct packed {
      logic nmi;
      logic maskable;
      logic ext_pin;
      logic standby_capable;
      logic above_service;
      logic ints_enabled;
   } wake_req_s;

   typedef struct packed {
      logic cpu;
      logic periph;
      logic main_osc;
      logic sub_osc;
      logic rom_corr;
      logic intc_release_only;
      logic serial_ext_only;
   } clock_ctl_s;

endpackage

/* core/settle_counter.sv */
`timescale 1ns/1ps
module settle_counter #(
   parameter int SHORT_EXP     = standby_pkg::SHORT_EXP,
   parameter int LONG_EXP_BASE = standby_pkg::LONG_EXP_BASE
) (
   input  wire logic       i_clock,
   input  wire logic       i_srst,
   input  wire logic       i_arm,
   input  wire logic       i_osc_running,
   input  wire logic       i_osc_tick,
   input  wire logic [2:0] i_sel,
   output logic            o_done
);

   logic [standby_pkg::CNT_W-1:0] count;
   logic [standby_pkg::CNT_W-1:0] target;
   logic [4:0]                    exp_sel;
   wire                           step;

   // code 0 is the short wait, codes 1..7 step from 2^16 upward
   assign exp_sel = (i_sel == 3'h0) ? 5'(SHORT_EXP)
                                    : 5'(LONG_EXP_BASE) + {2'h0, i_sel};
   assign target  = standby_pkg::CNT_W'(1) << exp_sel;
   // ticks of the restarting main oscillator, only once it swings
   assign step    = i_arm && i_osc_running && i_osc_tick && !o_done;
   assign o_done  = i_arm && (count == target);

   always_ff @(posedge i_clock) begin
      if (i_srst || !i_arm) begin
         count <= '0;
      end else if (step) begin
         count <= count + standby_pkg::CNT_W'(1);
      end
   end

   a_count_waits_osc : assert property (@(posedge i_clock) disable iff (i_srst)
      (i_arm && !i_osc_running) |=> (count == $past(count)))
      else $error("settle count moved before oscillator start");
   a_done_exact_len : assert property (@(posedge i_clock) disable iff (i_srst)
      $rose(o_done) |-> (count == target) && $past(step))
      else $error("settle wait ended at wrong count");

endmodule // settle_counter

/* core/wake_arbiter.sv */
`timescale 1ns/1ps
module wake_arbiter (
   input  wire standby_pkg::mode_e     i_mode,
   input  wire standby_pkg::wake_req_s i_req,
   output logic                        o_release,
   output logic                        o_ack,
   output logic                        o_to_handler
);

   wire halt_wake;
   wire deep_wake;

   // halt has the whole interrupt controller awake
   assign halt_wake = i_req.nmi || i_req.maskable;
   // idle/stop: only the pin sources and peripherals still clocked
   assign deep_wake = i_req.nmi || i_req.ext_pin || i_req.standby_capable;

   assign o_release = ((i_mode == standby_pkg::ST_HALT) && halt_wake) ||
                      (((i_mode == standby_pkg::ST_IDLE) ||
                        (i_mode == standby_pkg::ST_STOP)) && deep_wake);
   // lower priority than in-service: wakes only, stays pending
   assign o_ack        = o_release && (i_req.nmi || i_req.above_service);
   assign o_to_handler = o_ack && (i_req.nmi || i_req.ints_enabled);

endmodule // wake_arbiter

/* core/standby_mode_controller.sv */
`timescale 1ns/1ps
// Operation
// - select code 0 is 2^14, 1..7 2^16..2^22
// - select resets to 04H, 2^19 after reset
// - settle count starts after oscillator swings
// - halt gates CPU clock and ROM correction
// - pending request at halt exits at once
// - halt exits on NMI, unmasked request, reset
// - lower priority request ends halt only
// - higher priority request ends halt, acknowledged
// - handler or next instruction per source, enable
// - reset pin release is the normal reset
// - in halt peripherals run, ROM correction stops
// - standby request with select 0 enters idle
// - idle keeps oscillator, no settle wait
// - idle exits on NMI, pins, capable peripherals
// - idle wake priority: pend or acknowledge
// - idle/stop: controller only releases, only external-clock serial runs
// - standby request with select 1 enters stop
// - stop exits on NMI, pins, capable peripherals
// - CPU clock off until settle wait ends
// - control register needs protected write, resets 00H
// - stop/idle select matters only at request
module standby_mode_controller #(
   parameter int SHORT_EXP     = standby_pkg::SHORT_EXP,
   parameter int LONG_EXP_BASE = standby_pkg::LONG_EXP_BASE
) (
   input  wire logic                    i_clock,
   input  wire logic                    i_srst,
   input  wire logic                    i_halt_exec,
   input  wire standby_pkg::reg_write_s i_reg_write,
   input  wire standby_pkg::wake_req_s  i_wake,
   input  wire logic                    i_osc_running,
   input  wire logic                    i_osc_tick,
   output standby_pkg::clock_ctl_s      o_clock_ctl,
   output standby_pkg::mode_e           o_mode,
   output logic                         o_resume,
   output logic                         o_resume_ack,
   output logic                         o_resume_to_handler,
   output logic [7:0]                   o_osc_settle_select,
   output logic [7:0]                   o_power_save_control,
   output logic [7:0]                   o_power_save_mode_reg
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   standby_pkg::mode_e      state;
   standby_pkg::mode_e      next_state;
   standby_pkg::clock_ctl_s next_clock_ctl;

   logic       osc_meta;
   logic       osc_sync;
   logic       from_irq;
   logic       held_ack;
   logic       held_handler;
   logic       next_resume;
   logic       next_resume_ack;
   logic       next_resume_handler;
   logic       next_from_irq;
   logic [7:0] next_psc;

   logic       wake_release;
   logic       wake_ack;
   logic       wake_handler;
   logic       settle_done;

   wire        in_normal;
   wire        in_halt;
   wire        in_idle;
   wire        in_stop;
   wire        in_settle;
   wire        psc_hit;
   wire        psc_accept;
   wire        power_save_mode_reg_write;
   wire        settle_write;
   wire        standby_req;
   wire        enter_halt;
   wire        quick_release;
   wire        leave_settle;

   // ----------------------------------------------------------------
   // oscillator-running pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
      end else begin
         osc_meta <= i_osc_running;
         osc_sync <= osc_meta;
      end
   end

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   assign in_normal = (state == standby_pkg::ST_NORMAL);
   assign in_halt   = (state == standby_pkg::ST_HALT);
   assign in_idle   = (state == standby_pkg::ST_IDLE);
   assign in_stop   = (state == standby_pkg::ST_STOP);
   assign in_settle = (state == standby_pkg::ST_SETTLE);

   assign psc_hit      = i_reg_write.valid && (i_reg_write.sel == standby_pkg::SEL_PSC);
   // a stray store, e.g. from a runaway loop, is dropped here
   assign psc_accept   = psc_hit && i_reg_write.special_seq;
   assign power_save_mode_reg_write   = i_reg_write.valid && (i_reg_write.sel == standby_pkg::SEL_POWER_SAVE_MODE_REG);
   assign settle_write = i_reg_write.valid && (i_reg_write.sel == standby_pkg::SEL_SETTLE);

   assign enter_halt  = in_normal && i_halt_exec;
   // select bit only looked at in the cycle the request lands
   assign standby_req = in_normal && !i_halt_exec && psc_accept &&
                        i_reg_write.data[standby_pkg::STP_BIT];

   assign quick_release = (in_halt || in_idle) && wake_release;
   assign leave_settle  = in_settle && settle_done;

   // ----------------------------------------------------------------
   // sub blocks
   // ----------------------------------------------------------------
   wake_arbiter u_wake_arbiter (
      .i_mode       (state),
      .i_req        (i_wake),
      .o_release    (wake_release),
      .o_ack        (wake_ack),
      .o_to_handler (wake_handler)
   );

   settle_counter #(
      .SHORT_EXP     (SHORT_EXP),
      .LONG_EXP_BASE (LONG_EXP_BASE)
   ) u_settle_counter (
      .i_clock       (i_clock),
      .i_srst        (i_srst),
      .i_arm         (in_settle),
      .i_osc_running (osc_sync),
      .i_osc_tick    (i_osc_tick),
      .i_sel         (o_osc_settle_select[standby_pkg::SEL_MSB:0]),
      .o_done        (settle_done)
   );

   // ----------------------------------------------------------------
   // mode sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         standby_pkg::ST_NORMAL: begin
            if (enter_halt) begin
               next_state = standby_pkg::ST_HALT;
            end else if (standby_req) begin
               if (o_power_save_mode_reg[standby_pkg::PSM_BIT]) begin
                  next_state = standby_pkg::ST_STOP;
               end else begin
                  next_state = standby_pkg::ST_IDLE;
               end
            end
         end
         standby_pkg::ST_HALT: begin
            if (wake_release) begin
               next_state = standby_pkg::ST_NORMAL;
            end
         end
         standby_pkg::ST_IDLE: begin
            // oscillator never stopped, so straight back
            if (wake_release) begin
               next_state = standby_pkg::ST_NORMAL;
            end
         end
         standby_pkg::ST_STOP: begin
            if (wake_release) begin
               next_state = standby_pkg::ST_SETTLE;
            end
         end
         standby_pkg::ST_SETTLE: begin
            if (settle_done) begin
               next_state = standby_pkg::ST_NORMAL;
            end
         end
         default: begin
            next_state = standby_pkg::ST_SETTLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // clock and oscillator gating, following the next mode
   // ----------------------------------------------------------------
   assign next_clock_ctl.cpu      = (next_state == standby_pkg::ST_NORMAL);
   assign next_clock_ctl.periph   = (next_state == standby_pkg::ST_NORMAL) ||
                                    (next_state == standby_pkg::ST_HALT);
   assign next_clock_ctl.main_osc = (next_state != standby_pkg::ST_STOP);
   assign next_clock_ctl.sub_osc  = 1'b1;
   assign next_clock_ctl.rom_corr = (next_state == standby_pkg::ST_NORMAL);
   assign next_clock_ctl.intc_release_only = (next_state == standby_pkg::ST_IDLE) ||
                                             (next_state == standby_pkg::ST_STOP);
   assign next_clock_ctl.serial_ext_only   = (next_state == standby_pkg::ST_IDLE) ||
                                             (next_state == standby_pkg::ST_STOP);

   // ----------------------------------------------------------------
   // resume reporting to the CPU
   // ----------------------------------------------------------------
   // a stop release is only reported once the oscillator has settled
   assign next_from_irq       = (in_stop && wake_release) ? 1'b1 :
                                leave_settle ? 1'b0 : from_irq;
   assign next_resume         = quick_release || (leave_settle && from_irq);
   assign next_resume_ack     = quick_release ? wake_ack : held_ack;
   assign next_resume_handler = quick_release ? wake_handler : held_handler;

   // ----------------------------------------------------------------
   // control register: stop request bit drops on wake
   // ----------------------------------------------------------------
   assign next_psc = (psc_accept && in_normal) ? i_reg_write.data :
                     ((next_state == standby_pkg::ST_NORMAL) && !in_normal) ?
                     (o_power_save_control & ~(8'h01 << standby_pkg::STP_BIT)) :
                     o_power_save_control;

   // ----------------------------------------------------------------
   // state registers; i_srst is the normal reset sequence
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state <= standby_pkg::ST_SETTLE;
         o_clock_ctl <= '{cpu: 1'b0, periph: 1'b0, main_osc: 1'b1, sub_osc: 1'b1,
                          rom_corr: 1'b0, intc_release_only: 1'b0,
                          serial_ext_only: 1'b0};
      end else begin
         state       <= next_state;
         o_clock_ctl <= next_clock_ctl;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         from_irq            <= 1'b0;
         held_ack            <= 1'b0;
         held_handler        <= 1'b0;
         o_resume            <= 1'b0;
         o_resume_ack        <= 1'b0;
         o_resume_to_handler <= 1'b0;
      end else begin
         from_irq            <= next_from_irq;
         o_resume            <= next_resume;
         o_resume_ack        <= next_resume && next_resume_ack;
         o_resume_to_handler <= next_resume && next_resume_handler;
         if (in_stop && wake_release) begin
            held_ack     <= wake_ack;
            held_handler <= wake_handler;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_osc_settle_select   <= standby_pkg::SETTLE_SEL_RESET;
         o_power_save_control  <= standby_pkg::PSC_RESET;
         o_power_save_mode_reg <= standby_pkg::POWER_SAVE_MODE_REG_RESET;
      end else begin
         o_power_save_control <= next_psc;
         if (settle_write && in_normal) begin
            o_osc_settle_select <= i_reg_write.data;
         end
         if (power_save_mode_reg_write && in_normal) begin
            o_power_save_mode_reg <= i_reg_write.data;
         end
      end
   end

   assign o_mode = state;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_reset_settle_sel : assert property (@(posedge i_clock)
      $fell(i_srst) |-> (o_osc_settle_select == 8'h04) && in_settle && !o_clock_ctl.cpu)
      else $error("reset release not settling with select 04");
   a_halt_gates_cpu : assert property (@(posedge i_clock) disable iff (i_srst)
      in_halt |-> !o_clock_ctl.cpu && o_clock_ctl.periph && o_clock_ctl.main_osc
                  && !o_clock_ctl.rom_corr)
      else $error("halt clock gating wrong");
   a_halt_pending_exit : assert property (@(posedge i_clock) disable iff (i_srst)
      (enter_halt ##1 (i_wake.nmi || i_wake.maskable)) |=> in_normal && o_resume)
      else $error("pending request did not end halt at once");
   a_idle_entry : assert property (@(posedge i_clock) disable iff (i_srst)
      (standby_req && !o_power_save_mode_reg[standby_pkg::PSM_BIT])
      |=> in_idle && o_clock_ctl.main_osc && !o_clock_ctl.periph)
      else $error("idle not entered");
   a_stop_entry : assert property (@(posedge i_clock) disable iff (i_srst)
      (standby_req && o_power_save_mode_reg[standby_pkg::PSM_BIT])
      |=> in_stop && !o_clock_ctl.main_osc && o_clock_ctl.sub_osc)
      else $error("stop not entered");
   a_idle_no_settle : assert property (@(posedge i_clock) disable iff (i_srst)
      (in_idle && wake_release) |=> in_normal && o_clock_ctl.cpu && o_resume)
      else $error("idle release waited");
   a_stop_waits : assert property (@(posedge i_clock) disable iff (i_srst)
      (in_stop && wake_release) |=> in_settle && !o_clock_ctl.cpu && !o_resume)
      else $error("stop release skipped settle wait");
   a_settle_ends : assert property (@(posedge i_clock) disable iff (i_srst)
      (leave_settle && from_irq) |=> in_normal && o_resume
                                     && (o_resume_ack == $past(held_ack)))
      else $error("settle end not reported");
   a_psc_guarded : assert property (@(posedge i_clock) disable iff (i_srst)
      (psc_hit && !i_reg_write.special_seq && in_normal)
      |=> $stable(o_power_save_control) && in_normal)
      else $error("unprotected control write took effect");
   a_low_prio_pends : assert property (@(posedge i_clock) disable iff (i_srst)
      (quick_release && !i_wake.nmi && !i_wake.above_service) |=> !o_resume_ack)
      else $error("lower priority request acknowledged");
   a_nmi_branches : assert property (@(posedge i_clock) disable iff (i_srst)
      (quick_release && i_wake.nmi) |=> o_resume_ack && o_resume_to_handler)
      else $error("nmi wake did not branch");
   a_deep_stops_all : assert property (@(posedge i_clock) disable iff (i_srst)
      (in_idle || in_stop) |-> o_clock_ctl.intc_release_only && !o_clock_ctl.periph
                               && o_clock_ctl.serial_ext_only)
      else $error("peripherals running in idle or stop");
   a_high_prio_acks : assert property (@(posedge i_clock) disable iff (i_srst)
      (quick_release && (i_wake.nmi || i_wake.above_service)) |=> o_resume_ack)
      else $error("higher priority wake not acknowledged");
   a_settle_cpu_off : assert property (@(posedge i_clock) disable iff (i_srst)
      in_settle |-> !o_clock_ctl.cpu && o_clock_ctl.main_osc)
      else $error("cpu clocked or oscillator off during settle wait");
   a_idle_keeps_osc : assert property (@(posedge i_clock) disable iff (i_srst)
      in_idle |-> o_clock_ctl.main_osc && !o_clock_ctl.cpu)
      else $error("idle stopped the oscillator or ran the cpu");
   a_nmi_wakes_deep : assert property (@(posedge i_clock) disable iff (i_srst)
      ((in_idle || in_stop) && i_wake.nmi) |-> wake_release)
      else $error("nmi did not release idle or stop");
   a_req_bit_clears : assert property (@(posedge i_clock) disable iff (i_srst)
      (quick_release || leave_settle) |=> !o_power_save_control[standby_pkg::STP_BIT])
      else $error("standby request bit left set after release");

   c_halt_round : cover property (@(posedge i_clock) disable iff (i_srst)
      in_halt ##1 in_normal);
   c_idle_round : cover property (@(posedge i_clock) disable iff (i_srst)
      in_idle ##1 in_normal);
   c_stop_round : cover property (@(posedge i_clock) disable iff (i_srst)
      in_stop ##1 in_settle ##[1:1000] in_normal);
   c_pending_halt : cover property (@(posedge i_clock) disable iff (i_srst)
      enter_halt ##1 (in_halt && wake_release));
   c_low_prio_wake : cover property (@(posedge i_clock) disable iff (i_srst)
      quick_release && !i_wake.nmi && !i_wake.above_service);

endmodule // standby_mode_controller

/* verification/osc_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// main oscillator: silent start-up, then a tick every second cycle
// ----------------------------------------------------------------
module osc_model #(
   parameter int START = 6
) (
   input  wire logic i_clock,
   input  wire logic i_enable,
   output logic      o_running,
   output logic      o_tick
);
   int age = 0;
   // unknown enable counts as off so the model never sticks at x
   always @(posedge i_clock) begin
      age <= (i_enable === 1'b1) ? age + 1 : 0;
   end
   assign o_running = (age > START);
   assign o_tick    = o_running && age[0];
endmodule  // osc_model

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic                    i_clock = 1'b0;
   logic                    i_srst = 1'b1;
   logic                    halt = 1'b0;
   standby_pkg::reg_write_s wr = '0;
   logic [5:0]              wake = 6'h00;
   logic                    running;
   logic                    tick;
   standby_pkg::clock_ctl_s ck;
   standby_pkg::mode_e      mode;
   logic                    rs;
   logic                    rs_ack;
   logic                    rs_hdl;
   logic [7:0]              sel_q;
   logic [7:0]              psc_q;
   logic [7:0]              power_save_mode_reg_q;
   int                      n_errors = 0;
   int                      checks_done = 0;
   int                      cycles = 0;
   int                      n_tick = 0;

   standby_mode_controller #(.SHORT_EXP(2), .LONG_EXP_BASE(3)) standby_mode_controller_inst (
      .i_clock(i_clock), .i_srst(i_srst), .i_halt_exec(halt), .i_reg_write(wr), .i_wake(wake),
      .i_osc_running(running), .i_osc_tick(tick), .o_clock_ctl(ck), .o_mode(mode), .o_resume(rs),
      .o_resume_ack(rs_ack), .o_resume_to_handler(rs_hdl), .o_osc_settle_select(sel_q),
      .o_power_save_control(psc_q), .o_power_save_mode_reg(power_save_mode_reg_q));
   osc_model osc_model_inst (.i_clock(i_clock), .i_enable(ck.main_osc), .o_running(running),
      .o_tick(tick));

   initial begin
      forever #5 i_clock = ~i_clock;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (mode === standby_pkg::ST_SETTLE && tick === 1'b1) n_tick <= n_tick + 1;
      if (cycles == 10000) begin
         n_errors++;
         close_out();
      end
   end

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic step(input int n = 1);
      repeat (n) @(posedge i_clock);
   endtask

   task automatic write(input standby_pkg::reg_sel_e s, input logic [7:0] d, input logic sq);
      wr <= '{1'b1, s, d, sq};
      step();
      wr.valid <= 1'b0;
      step();
   endtask

   // waits for the resume pulse, or for normal mode when on_rs is 0
   task automatic wait_for(input int lim, input bit on_rs);
      int k;
      k = 0;
      while ((on_rs ? rs !== 1'b1 : mode !== standby_pkg::ST_NORMAL) && k < lim) begin
         step();
         k++;
      end
      chk("resume", {7'h0, rs}, {7'h0, on_rs});
      chk("ctl", 8'(ck), 8'h7c);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      int base;
      i_srst <= 1'b1;
      step(16);
      i_srst <= 1'b0;
      base = n_tick;
      step();
      chk("mode", 8'(mode), 8'h10);
      chk("sel", sel_q, 8'h04);
      chk("psc", psc_q, 8'h00);
      chk("power_save_mode_reg", power_save_mode_reg_q, 8'h00);
      wait_for(400, 1'b0);
      chk("ticks", 8'(n_tick - base >= 128 && n_tick - base <= 131), 8'h01);
   endtask

   task automatic t_halt(input logic [5:0] w, input logic pend, input logic [1:0] e);
      halt <= 1'b1;
      if (pend) wake <= w;
      step();
      halt <= 1'b0;
      if (!pend) begin
         step();
         chk("mode", 8'(mode), 8'h02);
         chk("ctl", 8'(ck), 8'h38);
         wake <= w;
      end
      wait_for(8, 1'b1);
      chk("ack", {6'h0, rs_ack, rs_hdl}, {6'h0, e});
      wake <= 6'h00;
      step(5);
   endtask

   task automatic t_idle();
      write(standby_pkg::SEL_POWER_SAVE_MODE_REG, 8'h00, 1'b0);
      write(standby_pkg::SEL_PSC, 8'h02, 1'b0);
      chk("psc", psc_q, 8'h00);
      chk("mode", 8'(mode), 8'h01);
      write(standby_pkg::SEL_PSC, 8'h02, 1'b1);
      chk("mode", 8'(mode), 8'h04);
      chk("ctl", 8'(ck), 8'h1b);
      wake <= 6'h13;
      step(4);
      chk("mode", 8'(mode), 8'h04);
      wake <= 6'h09;
      wait_for(4, 1'b1);
      chk("ack", {6'h0, rs_ack, rs_hdl}, 8'h00);
      chk("psc", psc_q, 8'h00);
      wake <= 6'h00;
      step(5);
   endtask

   task automatic t_stop(input logic [2:0] code);
      int base;
      int exp;
      exp = (code == 3'h0) ? 4 : 1 << (3 + code);
      write(standby_pkg::SEL_SETTLE, {5'h0, code}, 1'b0);
      chk("sel", sel_q, {5'h0, code});
      write(standby_pkg::SEL_POWER_SAVE_MODE_REG, 8'h01, 1'b0);
      chk("power_save_mode_reg", power_save_mode_reg_q, 8'h01);
      write(standby_pkg::SEL_PSC, 8'h02, 1'b1);
      chk("mode", 8'(mode), 8'h08);
      chk("ctl", 8'(ck), 8'h0b);
      base = n_tick;
      wake <= code[0] ? 6'h07 : 6'h0b;
      step(2);
      wake <= 6'h00;
      chk("cpu", {7'h0, ck.cpu}, 8'h00);
      wait_for(2500, 1'b1);
      chk("ack", {6'h0, rs_ack, rs_hdl}, 8'h03);
      chk("ticks", 8'(n_tick - base >= exp && n_tick - base <= exp + 3), 8'h01);
      step(5);
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      t_reset();
      t_halt(6'h11, 1'b0, 2'b00);
      t_halt(6'h12, 1'b0, 2'b10);
      t_halt(6'h20, 1'b1, 2'b11);
      t_idle();
      for (int c = 0; c < 8; c++) t_stop(3'(c));
      halt <= 1'b1;
      step();
      halt <= 1'b0;
      step(3);
      t_reset();
      close_out();
   end
endmodule  // testbench
